// ### rtl/ufl_defs.svh
// Constants for one serial channel: register offsets, fields, resets,
// timing counts and trigger tables. Included by bare name.
`ifndef UFL_DEFS_SVH
`define UFL_DEFS_SVH
`define UFL_A_DATA 4'h0
`define UFL_A_DIVH 4'h1
`define UFL_A_FIFO 4'h2
`define UFL_A_LINE 4'h3
`define UFL_A_MODEM 4'h4
`define UFL_A_STAT 4'h5
`define UFL_A_FEAT 4'h6
`define UFL_A_RX_TRIGGER_VALUE 4'h7
`define UFL_A_TX_TRIGGER_VALUE 4'h8
`define UFL_A_RXLVL 4'h9
`define UFL_A_TXLVL 4'ha
`define UFL_FC_EN 0
`define UFL_FC_RXRST 1
`define UFL_FC_TXRST 2
`define UFL_FC_DMA 3
`define UFL_LC_DLAB 7
`define UFL_LC_BRK 6
`define UFL_LC_FORCE 5
`define UFL_LC_EVEN 4
`define UFL_LC_PEN 3
`define UFL_LC_STOP 2
`define UFL_MC_PRE 7
`define UFL_MC_IR 6
`define UFL_FT_RXINV 4
`define UFL_RST_REG 8'h00
`define UFL_LINE_IDLE 1'b1
`define UFL_ISR_RX 5'h02
`define UFL_ISR_TX 5'h01
`define UFL_ISR_NONE 5'h00
`define UFL_OVS 6'h10
`define UFL_HALF 6'h08
`define UFL_STOP15 6'h18
`define UFL_STOP2 6'h20
`define UFL_IR_LO 6'h06
`define UFL_IR_HI 6'h09
`define UFL_PRE_LAST 2'h3
`define UFL_STRAP_AT 2'h2
`define UFL_DEPTH 7'h40
`define UFL_ONE 7'h01
`define UFL_TA_RX {7'h0e, 7'h08, 7'h04, 7'h01}
`define UFL_TB_RX {7'h1c, 7'h18, 7'h10, 7'h08}
`define UFL_TB_TX {7'h1e, 7'h18, 7'h08, 7'h10}
`define UFL_TC_RX {7'h3c, 7'h38, 7'h10, 7'h08}
`define UFL_TC_TX {7'h38, 7'h20, 7'h10, 7'h08}
`endif

// ### rtl/ufl_pkg.sv
// Types shared by the channel control block.
// Assumes ufl_defs.svh is compiled alongside for the constants.
package ufl_pkg;
    // Software-visible settings kept together
    typedef struct packed {
        logic       fen;
        logic       dma;
        logic [1:0] rxsel;
        logic [1:0] txsel;
        logic [7:0] line;
        logic [7:0] modem;
        logic [7:0] feat;
        logic [7:0] rxtv;
        logic [7:0] txtv;
        logic [7:0] divl;
        logic [7:0] divh;
        logic [7:0] divf;
    } ufl_cfg_s;

    typedef enum logic [4:0] {
        S_IDLE  = 5'h01,
        S_START = 5'h02,
        S_DATA  = 5'h04,
        S_PAR   = 5'h08,
        S_STOP  = 5'h10
    } ufl_ser_e;

    // State of one serial engine
    typedef struct packed {
        ufl_ser_e   st;
        logic [5:0] tk;
        logic [2:0] bi;
        logic [7:0] sh;
        logic       par;
    } ufl_ser_s;
endpackage : ufl_pkg

// ### rtl/ufl_chan.sv
// One serial channel: control registers, two 64-byte FIFOs, framing,
// prescaled baud ticks and infrared coding.
// Assumes a single 250 MHz clock and a host on the plain register port.
//
// The address map and strobed register access were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "ufl_defs.svh"
module ufl_chan (
    input  wire logic       clk,
    input  wire logic       sys_rst,
    input  wire logic [3:0] addr,
    input  wire logic [7:0] wdata,
    input  wire logic       wr_stb,
    input  wire logic       rd_stb,
    output logic      [7:0] rdata,
    input  wire logic       serial_rx,
    input  wire logic       infrared_strap_pin,
    output logic            serial_tx,
    output logic            rx_irq,
    output logic            tx_irq
);
    ufl_pkg::ufl_cfg_s cfg;
    ufl_pkg::ufl_cfg_s next_cfg;
    ufl_pkg::ufl_ser_s tx;
    ufl_pkg::ufl_ser_s next_tx;
    ufl_pkg::ufl_ser_s rx;
    ufl_pkg::ufl_ser_s next_rx;
    logic [2:0]  rx_sy;
    logic [2:0]  st_sy;
    logic        rx_f;
    logic        next_rx_f;
    logic [1:0]  st_cnt;
    logic [1:0]  next_st_cnt;
    logic [1:0]  pre;
    logic [15:0] bcnt;
    logic [15:0] next_bcnt;
    logic        tick;
    logic        next_tick;
    logic [5:0]  hold;
    logic [5:0]  next_hold;
    logic [7:0]  txm [64];
    logic [7:0]  rxm [64];
    logic [5:0]  txw;
    logic [5:0]  txr;
    logic [5:0]  rxw;
    logic [5:0]  rxr;
    logic [6:0]  txc;
    logic [6:0]  rxc;
    logic [5:0]  next_txw;
    logic [5:0]  next_txr;
    logic [5:0]  next_rxw;
    logic [5:0]  next_rxr;
    logic [6:0]  next_txc;
    logic [6:0]  next_rxc;
    logic        perr;
    logic        next_perr;
    logic        next_rx_irq;
    logic        next_tx_irq;
    logic [7:0]  next_rdata;
    logic        next_serial_tx;
    logic        tx_pop;
    logic        rx_push;
    logic        rx_perr;
    logic [7:0]  rx_byte;
    logic        line_bit;
    logic        rx_line;
    logic        ir_in;
    logic [5:0]  ttlen;
    logic [5:0]  rtlen;
    logic        tend;
    logic        rend;
    logic [6:0]  ttrig;
    logic [6:0]  rtrig;
    logic [7:0]  isr;

    // Word length as the index of the last data bit, 4 to 7
    function automatic logic [2:0] last_bit(input logic [7:0] lc);
        last_bit = {1'b1, lc[1:0]};
    endfunction : last_bit

    // Parity over the selected data bits; forced or odd/even
    function automatic logic par_bit(input logic [7:0] d, input logic [7:0] lc);
        logic [7:0] m;
        m = 8'hff >> (2'h3 - lc[1:0]);
        if (lc[`UFL_LC_FORCE]) begin
            par_bit = ~lc[`UFL_LC_EVEN];
        end else begin
            par_bit = (^(d & m)) ^ ~lc[`UFL_LC_EVEN];
        end
    endfunction : par_bit

    // Trigger level from table and field; table 3 uses the programmed value
    function automatic logic [6:0] trig(input logic [1:0] tbl, input logic [1:0] sel,
                                        input logic is_tx, input logic [7:0] prog);
        logic [27:0] row;
        row = 28'h0;
        if (tbl == 2'h0) begin
            row = is_tx ? {4{`UFL_ONE}} : `UFL_TA_RX;
        end else if (tbl == 2'h1) begin
            row = is_tx ? `UFL_TB_TX : `UFL_TB_RX;
        end else if (tbl == 2'h2) begin
            row = is_tx ? `UFL_TC_TX : `UFL_TC_RX;
        end else begin
            row = {4{prog[6:0]}};
        end
        trig = 7'(row >> (5'(sel) * 5'h07));
    endfunction : trig

    // Address qualifiers; divisor access steals the low addresses
    wire dlab   = cfg.line[`UFL_LC_DLAB];
    wire wr_thr = wr_stb && addr == `UFL_A_DATA && !dlab;
    wire rd_rhr = rd_stb && addr == `UFL_A_DATA && !dlab;
    wire wr_fcr = wr_stb && addr == `UFL_A_FIFO && !dlab;
    wire rd_isr = rd_stb && addr == `UFL_A_FIFO && !dlab;
    wire tx_fl  = wr_fcr && wdata[`UFL_FC_EN] && wdata[`UFL_FC_TXRST];
    wire rx_fl  = wr_fcr && wdata[`UFL_FC_EN] && wdata[`UFL_FC_RXRST];
    wire [6:0] cap = cfg.fen ? `UFL_DEPTH : `UFL_ONE;
    wire tx_push = wr_thr && txc < cap;
    wire rx_pop  = rd_rhr && rxc != 7'h00;
    wire ir_en   = cfg.modem[`UFL_MC_IR];

    // Trigger selection; the table field applies to both directions
    always_comb begin
        ttrig = cfg.fen ? trig(cfg.feat[7:6], cfg.txsel, 1'b1, cfg.txtv) : `UFL_ONE;
        rtrig = cfg.fen ? trig(cfg.feat[7:6], cfg.rxsel, 1'b0, cfg.rxtv) : `UFL_ONE;
        if (rtrig == 7'h00) begin
            rtrig = `UFL_ONE;
        end
        if (rx_irq) begin
            isr = {{2{cfg.fen}}, `UFL_ISR_RX, 1'b0};
        end else if (tx_irq) begin
            isr = {{2{cfg.fen}}, `UFL_ISR_TX, 1'b0};
        end else begin
            isr = {{2{cfg.fen}}, `UFL_ISR_NONE, 1'b1};
        end
    end

    // Pin synchronisers: a change counts once stages two and three agree
    always_comb begin
        next_rx_f = (rx_sy[1] == rx_sy[2]) ? rx_sy[2] : rx_f;
        // Count waits at the load point until the strap has settled
        next_st_cnt = (st_cnt == `UFL_PRE_LAST ||
                       (st_cnt == `UFL_STRAP_AT && st_sy[1] != st_sy[2])) ? st_cnt : st_cnt + 2'h1;
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rx_sy  <= 3'h7;
            st_sy  <= 3'h0;
            rx_f   <= `UFL_LINE_IDLE;
            st_cnt <= 2'h0;
        end else begin
            rx_sy  <= {rx_sy[1:0], serial_rx};
            st_sy  <= {st_sy[1:0], infrared_strap_pin};
            rx_f   <= next_rx_f;
            st_cnt <= next_st_cnt;
        end
    end

    // Prescaler and 16x baud tick; divisor fraction is held only
    always_comb begin
        next_bcnt = bcnt;
        next_tick = 1'b0;
        if (!cfg.modem[`UFL_MC_PRE] || pre == `UFL_PRE_LAST) begin
            if (bcnt <= 16'h0001) begin
                next_bcnt = {cfg.divh, cfg.divl};
                next_tick = 1'b1;
            end else begin
                next_bcnt = bcnt - 16'h0001;
            end
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pre  <= 2'h0;
            bcnt <= 16'h0000;
            tick <= 1'b0;
        end else begin
            pre  <= pre + 2'h1;
            bcnt <= next_bcnt;
            tick <= next_tick;
        end
    end

    // Transmit engine; the shift register survives a FIFO reset
    always_comb begin
        next_tx = tx;
        tx_pop  = 1'b0;
        line_bit = `UFL_LINE_IDLE;
        if (tx.st == ufl_pkg::S_STOP) begin
            ttlen = !cfg.line[`UFL_LC_STOP] ? `UFL_OVS :
                    (cfg.line[1:0] == 2'h0) ? `UFL_STOP15 : `UFL_STOP2;
        end else begin
            ttlen = `UFL_OVS;
        end
        tend = tick && tx.tk == ttlen - 6'h01;
        if (tick && tx.st != ufl_pkg::S_IDLE) begin
            next_tx.tk = tend ? 6'h00 : tx.tk + 6'h01;
        end
        case (tx.st)
            ufl_pkg::S_IDLE: begin
                if (txc != 7'h00) begin
                    tx_pop     = 1'b1;
                    next_tx.sh = txm[txr];
                    next_tx.par = par_bit(txm[txr], cfg.line);
                    next_tx.tk = 6'h00;
                    next_tx.st = ufl_pkg::S_START;
                end
            end
            ufl_pkg::S_START: begin
                line_bit = 1'b0;
                if (tend) begin
                    next_tx.bi = 3'h0;
                    next_tx.st = ufl_pkg::S_DATA;
                end
            end
            ufl_pkg::S_DATA: begin
                line_bit = tx.sh[tx.bi];
                if (tend) begin
                    next_tx.bi = tx.bi + 3'h1;
                    if (tx.bi == last_bit(cfg.line)) begin
                        next_tx.st = cfg.line[`UFL_LC_PEN] ? ufl_pkg::S_PAR
                                                           : ufl_pkg::S_STOP;
                    end
                end
            end
            ufl_pkg::S_PAR: begin
                line_bit = tx.par;
                if (tend) begin
                    next_tx.st = ufl_pkg::S_STOP;
                end
            end
            ufl_pkg::S_STOP: begin
                if (tend) begin
                    next_tx.st = ufl_pkg::S_IDLE;
                end
            end
            default: begin
                next_tx.st = ufl_pkg::S_IDLE;
            end
        endcase
        // Infrared sends a short high pulse for each zero, idles low
        if (cfg.line[`UFL_LC_BRK]) begin
            next_serial_tx = 1'b0;
        end else if (ir_en) begin
            next_serial_tx = !line_bit && tx.tk >= `UFL_IR_LO && tx.tk < `UFL_IR_HI;
        end else begin
            next_serial_tx = line_bit;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            tx        <= '{ufl_pkg::S_IDLE, 6'h00, 3'h0, 8'h00, 1'b0};
            serial_tx <= `UFL_LINE_IDLE;
        end else begin
            tx        <= next_tx;
            serial_tx <= next_serial_tx;
        end
    end

    // Receive front end; a pulse stretched one bit time reads as zero
    always_comb begin
        ir_in = rx_f ^ cfg.feat[`UFL_FT_RXINV];
        next_hold = hold;
        if (ir_in) begin
            next_hold = `UFL_OVS;
        end else if (tick && hold != 6'h00) begin
            next_hold = hold - 6'h01;
        end
        rx_line = ir_en ? !(ir_in || hold != 6'h00) : rx_f;
    end

    // Receive engine; samples mid-bit, checks parity at the stop bit
    always_comb begin
        next_rx = rx;
        rx_push = 1'b0;
        rx_perr = 1'b0;
        rx_byte = 8'(rx.sh >> (3'h7 - last_bit(cfg.line)));
        rtlen = (rx.st == ufl_pkg::S_START) ? `UFL_HALF : `UFL_OVS;
        rend = tick && rx.tk == rtlen - 6'h01;
        if (tick && rx.st != ufl_pkg::S_IDLE) begin
            next_rx.tk = rend ? 6'h00 : rx.tk + 6'h01;
        end
        case (rx.st)
            ufl_pkg::S_IDLE: begin
                if (!rx_line) begin
                    next_rx.tk = 6'h00;
                    next_rx.st = ufl_pkg::S_START;
                end
            end
            ufl_pkg::S_START: begin
                if (rend) begin
                    next_rx.bi = 3'h0;
                    next_rx.st = rx_line ? ufl_pkg::S_IDLE : ufl_pkg::S_DATA;
                end
            end
            ufl_pkg::S_DATA: begin
                if (rend) begin
                    next_rx.sh = {rx_line, rx.sh[7:1]};
                    next_rx.bi = rx.bi + 3'h1;
                    if (rx.bi == last_bit(cfg.line)) begin
                        next_rx.st = cfg.line[`UFL_LC_PEN] ? ufl_pkg::S_PAR
                                                           : ufl_pkg::S_STOP;
                    end
                end
            end
            ufl_pkg::S_PAR: begin
                if (rend) begin
                    next_rx.par = rx_line;
                    next_rx.st  = ufl_pkg::S_STOP;
                end
            end
            ufl_pkg::S_STOP: begin
                if (rend) begin
                    rx_push = rxc < cap; // Overrun drops the character
                    rx_perr = cfg.line[`UFL_LC_PEN] &&
                              rx.par != par_bit(rx_byte, cfg.line);
                    next_rx.st = ufl_pkg::S_IDLE;
                end
            end
            default: begin
                next_rx.st = ufl_pkg::S_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rx   <= '{ufl_pkg::S_IDLE, 6'h00, 3'h0, 8'h00, 1'b0};
            hold <= 6'h00;
        end else begin
            rx   <= next_rx;
            hold <= next_hold;
        end
    end

    // FIFO pointers and levels; a reset write clears only these
    always_comb begin
        next_txw = tx_push ? txw + 6'h01 : txw;
        next_txr = tx_pop ? txr + 6'h01 : txr;
        next_txc = 7'(txc + {6'h00, tx_push} - {6'h00, tx_pop});
        next_rxw = rx_push ? rxw + 6'h01 : rxw;
        next_rxr = rx_pop ? rxr + 6'h01 : rxr;
        next_rxc = 7'(rxc + {6'h00, rx_push} - {6'h00, rx_pop});
        if (tx_fl) begin
            next_txw = 6'h00;
            next_txr = 6'h00;
            next_txc = 7'h00;
        end
        if (rx_fl) begin
            next_rxw = 6'h00;
            next_rxr = 6'h00;
            next_rxc = 7'h00;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            txw <= 6'h00;
            txr <= 6'h00;
            txc <= 7'h00;
            rxw <= 6'h00;
            rxr <= 6'h00;
            rxc <= 7'h00;
        end else begin
            txw <= next_txw;
            txr <= next_txr;
            txc <= next_txc;
            rxw <= next_rxw;
            rxr <= next_rxr;
            rxc <= next_rxc;
        end
    end

    // Storage is plain flops without reset; contents are don't-care
    always_ff @(posedge clk) begin
        if (tx_push) begin
            txm[txw] <= wdata;
        end
        if (rx_push) begin
            rxm[rxw] <= rx_byte;
        end
    end

    // Register writes, reads and flags; hardware set beats software clear
    always_comb begin
        next_cfg = cfg;
        if (st_cnt == `UFL_STRAP_AT && st_sy[1] == st_sy[2]) begin
            next_cfg.modem[`UFL_MC_IR] = st_sy[2];
        end
        if (wr_stb) begin
            if (addr == `UFL_A_DATA && dlab) begin
                next_cfg.divl = wdata;
            end else if (addr == `UFL_A_DIVH && dlab) begin
                next_cfg.divh = wdata;
            end else if (addr == `UFL_A_FIFO && dlab) begin
                next_cfg.divf = wdata;
            end else if (addr == `UFL_A_FIFO) begin
                next_cfg.fen = wdata[`UFL_FC_EN];
                if (wdata[`UFL_FC_EN]) begin
                    next_cfg.dma   = wdata[`UFL_FC_DMA];
                    next_cfg.rxsel = wdata[7:6];
                    next_cfg.txsel = wdata[5:4];
                end
            end else if (addr == `UFL_A_LINE) begin
                next_cfg.line = wdata;
            end else if (addr == `UFL_A_MODEM) begin
                next_cfg.modem = wdata;
            end else if (addr == `UFL_A_FEAT) begin
                next_cfg.feat = wdata;
            end else if (addr == `UFL_A_RX_TRIGGER_VALUE) begin
                next_cfg.rxtv = wdata;
            end else if (addr == `UFL_A_TX_TRIGGER_VALUE) begin
                next_cfg.txtv = wdata;
            end
        end
        next_rdata = `UFL_RST_REG;
        if (rd_stb) begin
            if (addr == `UFL_A_DATA) begin
                next_rdata = dlab ? cfg.divl : (rxc != 7'h00 ? rxm[rxr] : 8'h00);
            end else if (addr == `UFL_A_DIVH) begin
                next_rdata = dlab ? cfg.divh : 8'h00;
            end else if (addr == `UFL_A_FIFO) begin
                next_rdata = dlab ? cfg.divf : isr;
            end else if (addr == `UFL_A_LINE) begin
                next_rdata = cfg.line;
            end else if (addr == `UFL_A_MODEM) begin
                next_rdata = cfg.modem;
            end else if (addr == `UFL_A_STAT) begin
                next_rdata = {5'h00, txc == 7'h00, perr, rxc != 7'h00};
            end else if (addr == `UFL_A_FEAT) begin
                next_rdata = cfg.feat;
            end else if (addr == `UFL_A_RX_TRIGGER_VALUE) begin
                next_rdata = cfg.rxtv;
            end else if (addr == `UFL_A_TX_TRIGGER_VALUE) begin
                next_rdata = cfg.txtv;
            end else if (addr == `UFL_A_RXLVL) begin
                next_rdata = {1'b0, rxc};
            end else if (addr == `UFL_A_TXLVL) begin
                next_rdata = {1'b0, txc};
            end
        end
        next_perr = rx_perr || (perr && !(rd_stb && addr == `UFL_A_STAT));
        next_rx_irq = next_rxc >= rtrig;
        next_tx_irq = tx_irq;
        if (wr_thr || (rd_isr && !rx_irq)) begin
            next_tx_irq = 1'b0;
        end
        if ((txc >= ttrig && next_txc < ttrig) || (txc != 7'h00 && next_txc == 7'h00)) begin
            next_tx_irq = 1'b1;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cfg    <= '0;
            rdata  <= `UFL_RST_REG;
            perr   <= 1'b0;
            rx_irq <= 1'b0;
            tx_irq <= 1'b0;
        end else begin
            cfg    <= next_cfg;
            rdata  <= next_rdata;
            perr   <= next_perr;
            rx_irq <= next_rx_irq;
            tx_irq <= next_tx_irq;
        end
    end
endmodule : ufl_chan
`default_nettype wire

// ### test/ufl_chan_checker.sv
// Port-level checks for the serial channel control block.
// Assumes bind onto ufl_chan; shadows host writes to know settings.
`timescale 1ns/1ps
`default_nettype none
module ufl_chan_checker (
    input wire logic       clk,
    input wire logic       sys_rst,
    input wire logic [3:0] addr,
    input wire logic [7:0] wdata,
    input wire logic       wr_stb,
    input wire logic       rd_stb,
    input wire logic [7:0] rdata,
    input wire logic       serial_tx,
    input wire logic       rx_irq,
    input wire logic       tx_irq
);
    logic [7:0] line_control;
    logic       fen;
    logic       pre;
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    // Shadow copies so no check needs design internals
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            line_control <= 8'h00;
            fen <= 1'b0;
            pre <= 1'b0;
        end else if (wr_stb) begin
            if (addr == 4'h3) line_control <= wdata;
            if (addr == 4'h2 && !line_control[7]) fen <= wdata[0];
            if (addr == 4'h4) pre <= wdata[7];
        end
    end
    sequence s_brk;
        line_control[6] [*3];
    endsequence
    property p_rd_idle;
        !$past(rd_stb) |-> rdata == 8'h00;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("rdata not idle");
    property p_stat_fen;
        rd_stb && addr == 4'h2 && !line_control[7] |=> rdata[7:6] == {2{$past(fen)}};
    endproperty
    a_stat_fen: assert property (p_stat_fen) else $error("status enable bits");
    property p_divh_hid;
        rd_stb && addr == 4'h1 && !line_control[7] |=> rdata == 8'h00;
    endproperty
    a_divh_hid: assert property (p_divh_hid) else $error("divisor seen");
    property p_line_rb;
        rd_stb && addr == 4'h3 |=> rdata == $past(line_control);
    endproperty
    a_line_rb: assert property (p_line_rb) else $error("line readback");
    property p_pre_rb;
        rd_stb && addr == 4'h4 |=> rdata[7] == $past(pre);
    endproperty
    a_pre_rb: assert property (p_pre_rb) else $error("prescale readback");
    property p_break;
        s_brk |-> !serial_tx;
    endproperty
    a_break: assert property (p_break) else $error("break not low");
    property p_tx_clr;
        wr_stb && addr == 4'h0 && !line_control[7] |=> !tx_irq;
    endproperty
    a_tx_clr: assert property (p_tx_clr) else $error("tx irq kept");
    property p_rx_stat;
        rd_stb && addr == 4'h2 && !line_control[7] && rx_irq |=> !rdata[0];
    endproperty
    a_rx_stat: assert property (p_rx_stat) else $error("rx not pending");
endmodule : ufl_chan_checker
bind ufl_chan ufl_chan_checker chk (.clk(clk), .sys_rst(sys_rst), .addr(addr),
    .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
    .serial_tx(serial_tx), .rx_irq(rx_irq), .tx_irq(tx_irq));
`default_nettype wire

// ### test/ufl_line_model.sv
// Remote serial end: drives the receive line, samples the transmit line.
// Assumes 16 clocks a bit (divisor one, no prescale).
`timescale 1ns/1ps
`default_nettype none
module ufl_line_model (
    input  wire logic clk,
    input  wire logic line_in,
    output logic      line_out
);
    initial line_out = 1'b1;
    // Frame bit 0 first; idle mark outside frames
    task automatic send(input logic [11:0] frame);
        for (int i = 0; i < 12; i++) begin
            line_out <= frame[i];
            repeat (16) @(posedge clk);
        end
    endtask : send
    // Bounded wait for start, then sample near each bit's middle
    task automatic grab(output logic [11:0] frame, output logic ok);
        ok = 1'b0;
        for (int i = 0; i < 4000 && !ok; i++) begin
            @(posedge clk);
            ok = !line_in;
        end
        repeat (7) @(posedge clk);
        for (int i = 0; i < 12; i++) begin
            frame[i] = line_in;
            repeat (16) @(posedge clk);
        end
    endtask : grab
endmodule : ufl_line_model
`default_nettype wire

// ### test/tb_ufl_chan.sv
// Self-checking bench: registers, framing, triggers, break, infrared.
// Assumes the line model on the far side and a divisor of one.
`timescale 1ns/1ps
`default_nettype none
module tb_ufl_chan;
    logic       clk;
    logic       sys_rst;
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr_stb;
    logic       rd_stb;
    logic       strap;
    logic [7:0] rdata;
    logic       serial_rx;
    logic       serial_tx;
    logic       rx_irq;
    logic       tx_irq;
    int         fails;
    int         check_count;
    ufl_chan uut (.clk(clk), .sys_rst(sys_rst), .addr(addr), .wdata(wdata),
        .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .serial_rx(serial_rx),
        .infrared_strap_pin(strap), .serial_tx(serial_tx), .rx_irq(rx_irq),
        .tx_irq(tx_irq));
    ufl_line_model lin (.clk(clk), .line_in(serial_tx), .line_out(serial_rx));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    task automatic print_verdict();
        if (fails == 0 && check_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : print_verdict
    task automatic ck(input string nm, input logic [11:0] e, input logic [11:0] g);
        check_count++;
        if (g !== e) begin
            fails++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask : ck
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc
    // An idle edge before each strobe keeps assignments one per step
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        addr   <= a;
        wdata  <= d;
        wr_stb <= 1'b1;
        @(posedge clk);
        wr_stb <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk);
        addr   <= a;
        rd_stb <= 1'b1;
        @(posedge clk);
        rd_stb <= 1'b0;
        #1 d = rdata;
    endtask : rd
    task automatic t_regs();
        logic [7:0] d;
        rd(4'h4, d);
        ck("strap", 12'h040, {4'h0, d});
        wr(4'h4, 8'h80);
        rd(4'h4, d);
        ck("modem", 12'h080, {4'h0, d});
        wr(4'h2, 8'h08);
        rd(4'h2, d);
        ck("status", 12'h001, {4'h0, d});
        wr(4'h3, 8'h80);
        wr(4'h0, 8'h01);
        wr(4'h1, 8'h00);
        rd(4'h0, d);
        ck("divl", 12'h001, {4'h0, d});
        wr(4'h3, 8'h03);
        rd(4'h1, d);
        ck("divh", 12'h000, {4'h0, d});
        rd(4'hf, d);
        ck("unmapped", 12'h000, {4'h0, d});
        wr(4'h4, 8'h00);
    endtask : t_regs
    // Each case: format byte and data; frame built bit by bit here
    task automatic t_frames();
        logic [7:0]  lc [4];
        logic [7:0]  dt [4];
        logic [7:0]  m;
        logic [11:0] f;
        logic [11:0] g;
        logic        ok;
        int          n;
        lc = '{8'h1b, 8'h0c, 8'h29, 8'h3e};
        dt = '{8'ha5, 8'h13, 8'h2d, 8'h55};
        for (int k = 0; k < 4; k++) begin
            n = 5 + lc[k][1:0];
            m = dt[k] & ~(8'hff << n);
            f = 12'hffe;
            for (int i = 0; i < n; i++) f[1+i] = m[i];
            if (lc[k][3]) f[1+n] = lc[k][5] ? ~lc[k][4] : (^m) ^ ~lc[k][4];
            wr(4'h3, lc[k]);
            wr(4'h0, dt[k]);
            lin.grab(g, ok);
            if (!ok) begin
                fails++;
                print_verdict();
            end
            ck("frame", f, g);
            ck("tx_irq", 12'h001, {11'h0, tx_irq});
        end
        rd(4'h2, g[7:0]);
        ck("tx status", 12'h002, {4'h0, g[7:0]});
        cyc(1);
        ck("tx_irq clr", 12'h000, {11'h0, tx_irq});
    endtask : t_frames
    task automatic t_rx();
        logic [7:0] d;
        wr(4'h2, 8'h01);
        wr(4'h3, 8'h03);
        lin.send({3'b111, 8'h3c, 1'b0});
        cyc(2);
        ck("rx_irq", 12'h001, {11'h0, rx_irq});
        rd(4'h2, d);
        rd(4'h0, d);
        ck("rx data", 12'h03c, {4'h0, d});
        cyc(2);
        ck("rx_irq low", 12'h000, {11'h0, rx_irq});
        lin.send({3'b111, 8'hc3, 1'b0});
        wr(4'h2, 8'h03);
        rd(4'h9, d);
        ck("rx level", 12'h000, {4'h0, d});
        ck("rx_irq rst", 12'h000, {11'h0, rx_irq});
    endtask : t_rx
    task automatic t_break_ir();
        wr(4'h3, 8'h43);
        cyc(3);
        ck("break", 12'h000, {11'h0, serial_tx});
        wr(4'h3, 8'h03);
        cyc(3);
        ck("mark", 12'h001, {11'h0, serial_tx});
        wr(4'h4, 8'h40);
        cyc(3);
        ck("ir idle", 12'h000, {11'h0, serial_tx});
    endtask : t_break_ir
    initial begin
        sys_rst = 1'b1;
        addr    = 4'h0;
        wdata   = 8'h00;
        wr_stb  = 1'b0;
        rd_stb  = 1'b0;
        strap   = 1'b1;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (4) @(posedge clk);
        t_regs();
        t_frames();
        t_rx();
        t_break_ir();
        print_verdict();
    end
endmodule : tb_ufl_chan
`default_nettype wire
